// ---- core/shared_io_port_defines.vh ----
/*
 * Register offsets, reset values and field positions of the six-bit
 * shared I/O port. Assumes it is included by bare name from core/.
 */
`ifndef SHARED_IO_PORT_DEFINES_VH
`define SHARED_IO_PORT_DEFINES_VH

// ----------------------------------------
// Register map (lower 16 address bits)
// ----------------------------------------
`define DIR_SEL_ADDR    16'hFFD0
`define OUT_VAL_ADDR    16'hFFD2

// ----------------------------------------
// Reset values and fixed read patterns
// ----------------------------------------
`define DIR_SEL_RESET   8'hC0
`define OUT_VAL_RESET   8'hC0
`define DIR_SEL_READ    8'hFF
`define RSVD_MASK       8'hC0
`define UNMAPPED_READ   8'h00

// ----------------------------------------
// Pin positions
// ----------------------------------------
`define PIN_TX0         0
`define PIN_TX1         1
`define PIN_RX0         2
`define PIN_RX1         3
`define PIN_SERIAL0_CLOCK_PIN        4
`define PIN_SERIAL1_CLOCK_PIN        5

`endif

// ---- core/shared_io_port.v ----
/*
 * Six-pin general purpose I/O port whose pins are shared with two serial
 * channels and two external interrupt request inputs.
 * Assumes a same-clock register master (one-cycle strobes, read data in the
 * next cycle) and serial channels that present their enables and outputs
 * on the system clock. Pins are asynchronous and are synchronised here.
 */
// Local design decision: the address-and-strobe port.
// What this block does
// RULE1 - Six bidirectional pins, each input or output
// RULE2 - Pins carry serial channel 0/1 signals
// RULE3 - Request 5/4 inputs follow pins when enabled
// RULE4 - Same pin functions in every mode
// RULE5 - Direction bit 1 output, 0 input
// RULE6 - Direction register write-only, reads all ones
// RULE7 - Reset loads direction with C0, all inputs
// RULE8 - Software standby holds direction and outputs
// RULE9 - Data register bits 5..0 hold outputs
// RULE10 - Output pins read back the data bit
// RULE11 - Input pins read back the pin level
// RULE12 - Data bits 7,6 ignore writes, read one
// RULE13 - Reset loads data C0, software standby keeps it
// RULE14 - Decode FFD0 and FFD2 on low 16 bits
// RULE15 - Channel 1 receive enable forces input
// RULE16 - Serial output overrides the data bit

`timescale 1ns/10ps
`include "shared_io_port_defines.vh"

module shared_io_port #(
  parameter ADDR_W = 16
) (
  input  wire              i_ref_clk,
  input  wire              i_rst_n,
  input  wire              i_hw_standby_n,
  input  wire              i_sw_standby,
  input  wire [ADDR_W-1:0] i_addr,
  input  wire [7:0]        i_wdata,
  input  wire              i_wr,
  input  wire              i_rd,
  output reg  [7:0]        o_rdata,
  input  wire [5:0]        i_pin,
  output wire [5:0]        o_pin,
  output wire [5:0]        o_pin_oe,
  input  wire [1:0]        i_interrupt_enable_bits,
  output wire              o_external_request_5_n,
  output wire              o_external_request_4_n,
  input  wire              i_serial0_tx_en,
  input  wire              i_serial0_tx,
  input  wire              i_serial0_receive_enable,
  output wire              o_serial0_rx,
  input  wire              i_serial0_clk_oe,
  input  wire              i_serial0_clk_out,
  output wire              o_serial0_clk_in,
  input  wire              i_serial1_tx_en,
  input  wire              i_serial1_tx,
  input  wire              i_serial1_receive_enable,
  output wire              o_serial1_rx,
  input  wire              i_serial1_clk_oe,
  input  wire              i_serial1_clk_out,
  output wire              o_serial1_clk_in
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function hit;
    input [15:0] a;
    input [15:0] ref_a;
    begin
      hit = (a == ref_a);
    end
  endfunction

  wire [15:0] addr_lo = i_addr[15:0];
  wire        dir_hit = hit(addr_lo, `DIR_SEL_ADDR); // RULE14
  wire        out_hit = hit(addr_lo, `OUT_VAL_ADDR); // RULE14

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [7:0] pin_direction_select_q;
  reg  [7:0] pin_output_value_q;
  reg  [7:0] pin_direction_select_d;
  reg  [7:0] pin_output_value_d;

  // Hardware standby acts like reset; software standby only blocks writes
  wire       init_n = i_rst_n & i_hw_standby_n;
  wire       wr_ok  = i_wr & ~i_sw_standby; // RULE8 RULE13

  always @* begin
    pin_direction_select_d = pin_direction_select_q;
    pin_output_value_d     = pin_output_value_q;
    if (wr_ok && dir_hit) begin
      pin_direction_select_d = `RSVD_MASK | i_wdata; // RULE5
    end else if (wr_ok && out_hit) begin
      pin_output_value_d = `RSVD_MASK | i_wdata; // RULE9 RULE12
    end
  end

  always @(posedge i_ref_clk or negedge init_n) begin
    if (!init_n) begin
      pin_direction_select_q <= `DIR_SEL_RESET; // RULE7
      pin_output_value_q     <= `OUT_VAL_RESET; // RULE13
    end else begin
      pin_direction_select_q <= pin_direction_select_d;
      pin_output_value_q     <= pin_output_value_d;
    end
  end

  // ----------------------------------------
  // Pin input synchroniser, three stages
  // ----------------------------------------
  reg  [5:0] sync1_q;
  reg  [5:0] sync2_q;
  reg  [5:0] sync3_q;
  reg  [5:0] pin_level_q;

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // Idle high, so active-low requests raise no false event after reset
      sync1_q     <= 6'h3F;
      sync2_q     <= 6'h3F;
      sync3_q     <= 6'h3F;
      pin_level_q <= 6'h3F;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      // A change counts only once two late stages agree
      pin_level_q <= (sync2_q & sync3_q) | (pin_level_q & (sync2_q | sync3_q));
    end
  end

  // ----------------------------------------
  // Pin function selection, mode independent
  // ----------------------------------------
  wire [5:0] ddr = pin_direction_select_q[5:0];
  wire [5:0] ser_oe;
  wire [5:0] ser_out;
  wire [5:0] ser_in_force;

  assign ser_oe = {i_serial1_clk_oe, i_serial0_clk_oe, 2'b00,
                   i_serial1_tx_en, i_serial0_tx_en}; // RULE2 RULE4
  assign ser_out = {i_serial1_clk_out, i_serial0_clk_out, 2'b00,
                    i_serial1_tx, i_serial0_tx}; // RULE2
  // Receive enable claims the pin as input over the direction bit
  assign ser_in_force = {2'b00, i_serial1_receive_enable, i_serial0_receive_enable,
                         2'b00}; // RULE15

  // A clock pin is never claimed as input; with its clock output off, the direction bit decides
  assign o_pin_oe = ~ser_in_force & (ser_oe | ddr); // RULE1 RULE5 RULE8
  assign o_pin    = (ser_oe & ser_out) |
                    (~ser_oe & pin_output_value_q[5:0]); // RULE16

  assign o_serial0_rx     = pin_level_q[`PIN_RX0];
  assign o_serial1_rx     = pin_level_q[`PIN_RX1];
  assign o_serial0_clk_in = pin_level_q[`PIN_SERIAL0_CLOCK_PIN];
  assign o_serial1_clk_in = pin_level_q[`PIN_SERIAL1_CLOCK_PIN];

  // Requests see the pin whatever its direction; idle high when disabled
  assign o_external_request_5_n = ~i_interrupt_enable_bits[1] |
                                  pin_level_q[`PIN_SERIAL1_CLOCK_PIN]; // RULE3
  assign o_external_request_4_n = ~i_interrupt_enable_bits[0] |
                                  pin_level_q[`PIN_SERIAL0_CLOCK_PIN]; // RULE3

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire [7:0] port_view = {2'b11, (ddr & pin_output_value_q[5:0]) |
                                 (~ddr & pin_level_q)}; // RULE10 RULE11 RULE12

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= `UNMAPPED_READ;
    end else if (i_rd && dir_hit) begin
      o_rdata <= `DIR_SEL_READ; // RULE6
    end else if (i_rd && out_hit) begin
      o_rdata <= port_view;
    end else begin
      o_rdata <= `UNMAPPED_READ;
    end
  end

endmodule // shared_io_port

// ---- bench/pin_world.sv ----
/* Far side of the six pins.
   Assumes the bench sets what the outside world drives. */
`timescale 1ns/10ps
module pin_world (
  input  wire [5:0] i_drv, i_oe, i_ext,
  output wire [5:0] o_lvl
);
  // Released pins show the outside level, never the last driven value
  assign o_lvl = (i_oe & i_drv) | (~i_oe & i_ext);
endmodule // pin_world

// ---- bench/sio_checker.sv ----
/* Port checker for the shared I/O port.
   Assumes it is bound to the top module. */
`timescale 1ns/10ps
module sio_checker #(parameter ADDR_W = 16) (
  input wire i_ref_clk, i_rst_n, i_hw_standby_n, i_sw_standby, i_wr, i_rd,
  input wire [ADDR_W-1:0] i_addr,
  input wire [7:0] i_wdata, o_rdata,
  input wire [5:0] i_pin, o_pin, o_pin_oe,
  input wire [1:0] i_interrupt_enable_bits,
  input wire o_external_request_5_n, o_external_request_4_n, i_serial0_tx_en, i_serial0_tx,
  input wire i_serial0_receive_enable, i_serial0_clk_oe, i_serial1_tx_en,
  input wire i_serial1_receive_enable, i_serial1_clk_oe
);
  wire [15:0] a = i_addr[15:0];
  // Serial claims alter pin drive, so plain port checks need them idle
  wire q = !(i_serial0_tx_en | i_serial0_receive_enable | i_serial0_clk_oe
           | i_serial1_tx_en | i_serial1_receive_enable | i_serial1_clk_oe);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n || !i_hw_standby_n);
  a_dir_reads_ones: assert property (
    i_rd && a == 16'hFFD0 |=> o_rdata == 8'hFF) else $error("bad dir read");
  a_idle_rdata_zero: assert property (
    !(i_rd && (a == 16'hFFD0 || a == 16'hFFD2)) |=> o_rdata == 8'h00) else $error("bad rdata");
  a_oe_follows_dir: assert property (
    i_wr && a == 16'hFFD0 && !i_sw_standby && q ##1 q |-> o_pin_oe == $past(i_wdata[5:0]))
    else $error("bad oe");
  a_standby_holds: assert property (
    i_sw_standby && q ##1 q |-> $stable(o_pin_oe) && $stable(o_pin & o_pin_oe))
    else $error("standby lost");
  a_reset_inputs: assert property (
    $rose(i_rst_n) && q |-> o_pin_oe == 6'h00) else $error("reset oe");
  a_tx_drives_pin: assert property (
    i_serial0_tx_en |-> o_pin_oe[0] && o_pin[0] == i_serial0_tx) else $error("tx pin");
  a_rx_forces_in: assert property (
    i_serial1_receive_enable |-> !o_pin_oe[3]) else $error("rx pin");
  a_req4_follows: assert property (
    (i_interrupt_enable_bits[0] && !i_pin[4]) [*6] |-> !o_external_request_4_n)
    else $error("req4 missing");
  a_req5_gated: assert property (
    !i_interrupt_enable_bits[1] [*2] |-> o_external_request_5_n) else $error("req5 ungated");
  cover property (i_wr && a == 16'hFFD0);
  cover property (i_sw_standby && i_wr);
  cover property (!o_external_request_4_n);
endmodule // sio_checker
bind shared_io_port sio_checker #(.ADDR_W(ADDR_W)) sio_checker_i (.*);

// ---- bench/shared_io_port_bench.sv ----
/* Bench for the shared I/O port: register tasks plus pin and serial stimulus.
   Assumes the checker binds itself. */
`timescale 1ns/10ps
module shared_io_port_bench;
  logic clk = 0, rst_n = 0, hws_n = 1, sws = 0, wr = 0, rd = 0, req5_n, req4_n;
  logic t0e = 0, t0 = 0, r0e = 0, c0e = 0, t1e = 0, r1e = 0, c1e = 0, c1 = 0;
  logic r0i, r1i, c0i, c1i;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata;
  logic [5:0] ext = 6'h2A, pin, po, oe;
  logic [1:0] ien = 2'h0;
  int num_errors = 0, compares = 0;
  initial forever #2.5 clk = ~clk;
  pin_world pin_world_i (.i_drv(po), .i_oe(oe), .i_ext(ext), .o_lvl(pin));
  shared_io_port shared_io_port_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_hw_standby_n(hws_n),
    .i_sw_standby(sws), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_pin(pin), .o_pin(po), .o_pin_oe(oe), .i_interrupt_enable_bits(ien),
    .o_external_request_5_n(req5_n), .o_external_request_4_n(req4_n), .i_serial0_tx_en(t0e),
    .i_serial0_tx(t0), .i_serial0_receive_enable(r0e), .o_serial0_rx(r0i),
    .i_serial0_clk_oe(c0e), .i_serial0_clk_out(1'b0), .o_serial0_clk_in(c0i),
    .i_serial1_tx_en(t1e), .i_serial1_tx(1'b0), .i_serial1_receive_enable(r1e),
    .o_serial1_rx(r1i), .i_serial1_clk_oe(c1e), .i_serial1_clk_out(c1),
    .o_serial1_clk_in(c1i));
  task chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task wr_r(logic [15:0] a, logic [7:0] d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask
  task rd_r(logic [15:0] a, logic [7:0] e);
    addr <= a; rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    #1 chk("rdata", e, rdata);
    @(posedge clk);
  endtask
  task end_sim;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #5000 num_errors++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("oe", 8'h00, {2'b00, oe});
    rd_r(16'hFFD0, 8'hFF);
    rd_r(16'hFFD2, 8'hEA);
    chk("ser_in", 8'h0A, {4'h0, c1i, c0i, r1i, r0i});
    wr_r(16'hFFD0, 8'h0F);
    wr_r(16'hFFD2, 8'h05);
    chk("oe", 8'h0F, {2'b00, oe});
    rd_r(16'hFFD2, 8'hE5);
    wr_r(16'hFFD2, 8'h3A);
    chk("pin", 8'h0A, {4'h0, po[3:0]});
    rd_r(16'hFFD2, 8'hEA);
    sws <= 1'b1;
    wr_r(16'hFFD2, 8'h05);
    wr_r(16'hFFD0, 8'h00);
    chk("oe", 8'h0F, {2'b00, oe});
    rd_r(16'hFFD2, 8'hEA);
    sws <= 1'b0;
    wr_r(16'hFFD4, 8'hFF);
    rd_r(16'hFFD4, 8'h00);
    rd_r(16'h00D2, 8'h00);
    rd_r(16'hFFD2, 8'hEA);
    t0e <= 1'b1; t0 <= 1'b1; c1e <= 1'b1; c1 <= 1'b1; r1e <= 1'b1;
    @(posedge clk) #1 chk("oe", 8'h27, {2'b00, oe});
    chk("pin", 8'h23, {2'b00, po & oe});
    t0e <= 1'b0; c1e <= 1'b0; r1e <= 1'b0; ien <= 2'h3;
    repeat (6) @(posedge clk);
    chk("req", 8'h02, {6'h00, req5_n, req4_n});
    ext <= 6'h1A;
    repeat (6) @(posedge clk);
    chk("req", 8'h01, {6'h00, req5_n, req4_n});
    ien <= 2'h0;
    repeat (2) @(posedge clk);
    chk("req", 8'h03, {6'h00, req5_n, req4_n});
    hws_n <= 1'b0;
    @(posedge clk) hws_n <= 1'b1;
    @(posedge clk) chk("oe", 8'h00, {2'b00, oe});
    wr_r(16'hFFD0, 8'h3F);
    rd_r(16'hFFD2, 8'hC0);
    end_sim;
  end
endmodule // shared_io_port_bench
